// ===== asc_pkg.sv
package asc_pkg;
   // register offsets
   localparam logic [12:0] ADDR_PORT_CFG     = 13'h0000;
   localparam logic [12:0] ADDR_OUT_MODE     = 13'h0008;
   localparam logic [12:0] ADDR_TEST_PAT     = 13'h000D;
   localparam logic [12:0] ADDR_SELF_CTRL    = 13'h000E;
   localparam logic [12:0] ADDR_OUT_PHASE    = 13'h0016;
   localparam logic [12:0] ADDR_SELF_RES     = 13'h0024;
   localparam logic [12:0] ADDR_XFER         = 13'h00FF;
   localparam logic [12:0] SHADOW_LO         = 13'h0008;
   localparam logic [12:0] SHADOW_HI         = 13'h0018;
   // field positions and values
   localparam int          MODE_FN_LSB       = 5;
   localparam logic [1:0]  MODE_FN_TRISTATE  = 2'h1;
   localparam int          FMT_LSB           = 0;
   localparam logic [1:0]  FMT_TWOS          = 2'h1;
   localparam int          LSB_FIRST_BIT     = 6;
   localparam int          DCO_INV_BIT       = 7;
   localparam int          ST_EN_BIT         = 0;
   localparam int          ST_INIT_BIT       = 2;
   localparam int          PAT_RST_A_BIT     = 4;
   localparam int          PAT_RST_B_BIT     = 5;
   localparam logic [7:0]  XFER_CMD          = 8'h01;
   // reset values
   localparam logic [7:0]  PORT_CFG_RST      = 8'h18;
   localparam logic [7:0]  REG_ZERO          = 8'h00;
   localparam logic [11:0] PRS_SEED          = 12'hABC;
   localparam logic [15:0] CRC_SEED          = 16'hFFFF;
   // expected self-test signature; arbitrary value
   localparam logic [15:0] SIG_EXPECT        = 16'h5A3C;
   // timing counts, sizes and code values
   localparam int          PIPE_DEPTH        = 9;
   localparam logic [9:0]  SELF_TEST_LEN     = 10'd512;
   localparam int          DATA_W            = 12;
   localparam int          FIFO_DEPTH        = 8;
   localparam logic [11:0] CODE_MAX          = 12'hFFF;
   localparam logic [11:0] CODE_MID          = 12'h800;

   // one converted sample with its range flag
   typedef struct packed {
      logic [11:0] code;
      logic        over;
   } asc_sample_t;

   typedef enum logic [2:0] {
      SP_IDLE  = 3'b000,
      SP_INSTR = 3'b001,
      SP_WDATA = 3'b010,
      SP_RDATA = 3'b011
   } asc_spi_state_t;
endpackage

// ===== asc_fifo.sv
`timescale 1ns/10ps
module asc_fifo
   import asc_pkg::*;
#(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk_i,    // clock
   input  wire logic             rst_i,    // sync reset
   input  wire logic [WIDTH-1:0] wdata_i,  // write data
   input  wire logic             wvalid_i, // write valid
   output logic                  wready_o, // not full
   output logic      [WIDTH-1:0] rdata_o,  // read data (combinational read of head entry)
   output logic                  rvalid_o, // not empty
   input  wire logic             rready_i  // drain
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic             push;
   logic             pop;
   logic             full;
   logic             empty;

   assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign empty    = (wp == rp);
   assign push     = wvalid_i && !full;
   assign pop      = rready_i && !empty;
   assign wready_o = !full;
   assign rvalid_o = !empty;
   assign rdata_o  = mem[rp[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wp[AW-1:0]] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp <= '0;
         rp <= '0;
      end
      else
      begin
         if (push)
         begin
            wp <= wp + 1'b1;
         end
         if (pop)
         begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule

// ===== asc_pipe.sv
`timescale 1ns/10ps
module asc_pipe
   import asc_pkg::*;
(
   input  wire logic        clk_i,   // clock
   input  wire logic        rst_i,   // sync reset
   input  wire logic        adv_i,   // sample clock event
   input  asc_sample_t      din_i,   // sample entering the pipe
   output asc_sample_t      dout_o   // sample leaving after PIPE_DEPTH events
);
   asc_sample_t stage [PIPE_DEPTH];

   genvar g;
   generate
      for (g = 0; g < PIPE_DEPTH; g++)
      begin : g_st
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               stage[g] <= '0;
            end
            else if (adv_i)
            begin
               stage[g] <= (g == 0) ? din_i : stage[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   assign dout_o = stage[PIPE_DEPTH-1];
endmodule

// ===== asc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - mode pin acts as output three-state only when bits 6:5 of 0x08 select it.
// - with three-state selected, pin low drives outputs, pin high floats them.
// - each sample appears on outputs nine sample clocks after it is taken.
// - data clock out provided; data valid on its rising edge unless inverted.
// - offset binary codes, clamp at limits, over-range flag past half LSB.
// - self-test feeds pseudo-random words into datapath, CRC accumulates at end.
// - self-test runs exactly 512 cycles, stops, compares signature to fixed value.
// - result bit 0 of 0x24 set on match, cleared on mismatch.
// - data outputs stay connected during self-test showing the pseudo-random words.
// - writing 0x05 to 0x0E: bit 0 enables test, bit 2 reseeds generator.
// - start without bit 2 continues sequence from last value.
// - test mode cuts converter off and routes patterns 1 and 2 through output formatting; pattern 6 bypasses it.
// - pattern generators reset when bit 4 or 5 of 0x0D set.
// - patterns advance only with sample clock, ignoring analog input.
// - frame starts at first shift-clock rise after chip select falls.
// - streaming and chip select pauses between bytes are both accepted.
// - chip select high releases the data pin; serial pins act as straps only until the first frame.
// - frame opens with 16-bit instruction: direction, length, address.
// - data in 8-bit bytes; read bit one means read, sent first frame bit MSB first, last LSB first.
// - on read, data pin turns to output after instruction and drives bytes.
// - MSB first after reset, LSB first when port config selects it.
// - serial port disabled: data pin high powers down, clock pin high twos complement.
// - writes to 0x08..0x18 except 0x0E shadowed, applied on 0x01 to 0xFF, bit self-clears.
module asc_top
   import asc_pkg::*;
(
   input  wire logic        clk_i,          // 100 MHz system clock
   input  wire logic        rst_i,          // sync reset, active high
   input  wire logic        samp_clk_i,     // sample clock, async
   input  wire logic [12:0] core_code_i,    // converter core code, 13 bits signed headroom
   input  wire logic        core_valid_i,   // core code valid (same domain)
   input  wire logic        tristate_pin_i, // output_tristate_pin, async
   input  wire logic        chip_select_n_i,// chip select, async
   input  wire logic        sclk_i,         // shift clock / format strap, async
   input  wire logic        sdio_i,         // serial data in / power-down strap, async
   output logic             sdio_o,         // serial data out
   output logic             sdio_oe_n_o,    // low while device drives sdio
   output logic [11:0]      data_o,         // latched data outputs
   output logic             data_oe_n_o,    // low while data pins driven
   output logic             out_of_range_o, // out_of_range_flag
   output logic             dco_o,          // data_clock_out
   output logic             dco_oe_n_o,     // low while data clock driven
   output logic             powerdown_o,    // power-down request
   output logic             core_ready_o    // core data accepted
);
   // ---------------- synchronisers ----------------
   logic [1:0] s_samp, s_oe, s_cs, s_sck, s_sdi;
   logic       samp_d, sck_d;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_samp <= '0;
         s_oe   <= '0;
         s_cs   <= 2'b11;
         s_sck  <= '0;
         s_sdi  <= '0;
         samp_d <= 1'b0;
         sck_d  <= 1'b0;
      end
      else
      begin
         s_samp <= {s_samp[0], samp_clk_i};
         s_oe   <= {s_oe[0], tristate_pin_i};
         s_cs   <= {s_cs[0], chip_select_n_i};
         s_sck  <= {s_sck[0], sclk_i};
         s_sdi  <= {s_sdi[0], sdio_i};
         samp_d <= s_samp[1];
         sck_d  <= s_sck[1];
      end
   end
   logic samp_rise, samp_fall, sck_rise, sck_fall, cs_n;
   assign samp_rise = s_samp[1] && !samp_d;
   assign samp_fall = !s_samp[1] && samp_d;
   assign sck_rise  = s_sck[1] && !sck_d;
   assign sck_fall  = !s_sck[1] && sck_d;
   assign cs_n      = s_cs[1];

   // ---------------- registers ----------------
   logic [7:0] port_cfg, sh_mode, sh_pat, sh_phase, act_mode, act_pat, act_phase;
   logic [7:0] self_ctrl, self_res;
   logic       spi_used;  // any frame seen: pins no longer treated as straps
   logic       wr_stb;
   logic [12:0] wr_addr;
   logic [7:0] wr_data;
   logic       st_start;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port_cfg  <= PORT_CFG_RST;
         sh_mode   <= REG_ZERO;
         sh_pat    <= REG_ZERO;
         sh_phase  <= REG_ZERO;
         act_mode  <= REG_ZERO;
         act_pat   <= REG_ZERO;
         act_phase <= REG_ZERO;
      end
      else if (wr_stb)
      begin
         case (wr_addr)
            ADDR_PORT_CFG:  port_cfg <= wr_data;
            ADDR_OUT_MODE:  sh_mode  <= wr_data;
            ADDR_TEST_PAT:  sh_pat   <= wr_data;
            ADDR_OUT_PHASE: sh_phase <= wr_data;
            ADDR_XFER:
            begin
               if (wr_data == XFER_CMD)
               begin
                  act_mode  <= sh_mode;
                  act_pat   <= sh_pat;
                  act_phase <= sh_phase;
               end
            end
            default: ;
         endcase
      end
   end

   // self-test control is live, not shadowed: a write with bit 0 set starts the run
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         self_ctrl <= REG_ZERO;
      end
      else if (wr_stb && wr_addr == ADDR_SELF_CTRL)
      begin
         self_ctrl <= wr_data;
      end
   end
   assign st_start = wr_stb && wr_addr == ADDR_SELF_CTRL && wr_data[ST_EN_BIT];

   // ---------------- serial port ----------------
   asc_spi_state_t st;
   logic [15:0] instr;
   logic [4:0]  bitcnt;
   logic [7:0]  sh_in, sh_out;
   logic [12:0] addr;
   logic [1:0]  len;
   logic [1:0]  bytes_done;
   logic        lsb_first;
   logic [7:0]  rd_val;
   assign lsb_first = port_cfg[LSB_FIRST_BIT];

   always_comb
   begin
      case (addr)
         ADDR_PORT_CFG:  rd_val = port_cfg;
         ADDR_OUT_MODE:  rd_val = sh_mode;
         ADDR_TEST_PAT:  rd_val = sh_pat;
         ADDR_SELF_CTRL: rd_val = self_ctrl;
         ADDR_OUT_PHASE: rd_val = sh_phase;
         ADDR_SELF_RES:  rd_val = self_res;
         default:        rd_val = REG_ZERO;
      endcase
   end

   logic [7:0] in_byte;
   assign in_byte = lsb_first ? {s_sdi[1], sh_in[7:1]} : {sh_in[6:0], s_sdi[1]};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st          <= SP_IDLE;
         instr       <= '0;
         bitcnt      <= '0;
         sh_in       <= '0;
         sh_out      <= '0;
         addr        <= '0;
         len         <= '0;
         bytes_done  <= '0;
         wr_stb      <= 1'b0;
         wr_addr     <= '0;
         wr_data     <= '0;
         sdio_o      <= 1'b0;
         sdio_oe_n_o <= 1'b1;
         spi_used    <= 1'b0;
      end
      else
      begin
         wr_stb <= 1'b0;
         if (cs_n)
         begin
            sdio_oe_n_o <= 1'b1;
            if (st == SP_IDLE)
            begin
               bitcnt <= '0;
            end
         end
         else if (sck_rise)
         begin
            spi_used <= 1'b1;
            case (st)
               SP_IDLE, SP_INSTR:
               begin
                  instr  <= lsb_first ? {s_sdi[1], instr[15:1]} : {instr[14:0], s_sdi[1]};
                  bitcnt <= bitcnt + 5'd1;
                  st     <= SP_INSTR;
                  if (bitcnt == 5'd15)
                  begin
                     bitcnt     <= '0;
                     bytes_done <= '0;
                     if (lsb_first)
                     begin
                        addr <= instr[13:1];
                        len  <= instr[15:14];
                        st   <= s_sdi[1] ? SP_RDATA : SP_WDATA;
                     end
                     else
                     begin
                        addr <= {instr[11:0], s_sdi[1]};
                        len  <= instr[13:12];
                        st   <= instr[14] ? SP_RDATA : SP_WDATA;
                     end
                  end
               end
               SP_WDATA:
               begin
                  sh_in  <= in_byte;
                  bitcnt <= bitcnt + 5'd1;
                  if (bitcnt == 5'd7)
                  begin
                     bitcnt     <= '0;
                     wr_stb     <= 1'b1;
                     wr_addr    <= addr;
                     wr_data    <= in_byte;
                     addr       <= addr - 13'd1;
                     bytes_done <= bytes_done + 2'd1;
                     if (len != 2'd3 && bytes_done == len)
                     begin
                        st <= SP_IDLE;
                     end
                  end
               end
               SP_RDATA:
               begin
                  bitcnt <= bitcnt + 5'd1;
                  if (bitcnt == 5'd7)
                  begin
                     bitcnt     <= '0;
                     addr       <= addr - 13'd1;
                     bytes_done <= bytes_done + 2'd1;
                     if (len != 2'd3 && bytes_done == len)
                     begin
                        st <= SP_IDLE;
                     end
                  end
               end
               default: st <= SP_IDLE;
            endcase
         end
         else if (sck_fall && st == SP_RDATA)
         begin
            sdio_oe_n_o <= 1'b0;
            if (bitcnt == 5'd0)
            begin
               sdio_o <= lsb_first ? rd_val[0] : rd_val[7];
               sh_out <= lsb_first ? {1'b0, rd_val[7:1]} : {rd_val[6:0], 1'b0};
            end
            else
            begin
               sdio_o <= lsb_first ? sh_out[0] : sh_out[7];
               sh_out <= lsb_first ? {1'b0, sh_out[7:1]} : {sh_out[6:0], 1'b0};
            end
         end
      end
   end

   // ---------------- self-test ----------------
   logic [11:0] prs;
   logic [15:0] crc;
   logic [9:0]  st_cnt;
   logic        st_run;
   logic [11:0] pat_prs;
   logic        prs_fb;
   assign prs_fb = prs[11] ^ prs[5] ^ prs[3] ^ prs[0];

   asc_sample_t pipe_out;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prs      <= PRS_SEED;
         crc      <= CRC_SEED;
         st_cnt   <= '0;
         st_run   <= 1'b0;
         self_res <= REG_ZERO;
      end
      else if (st_start)
      begin
         st_run   <= 1'b1;
         st_cnt   <= '0;
         crc      <= CRC_SEED;
         self_res <= REG_ZERO;                                   // cleared while running
         if (wr_data[ST_INIT_BIT])
         begin
            prs <= PRS_SEED;
         end                                                     // else continue
      end
      else if (st_run && samp_rise)
      begin
         prs    <= {prs[10:0], prs_fb};
         crc    <= {crc[14:0], 1'b0} ^ ({16{crc[15]}} & 16'h1021) ^ {4'h0, pipe_out.code};
         st_cnt <= st_cnt + 10'd1;
         if (st_cnt == SELF_TEST_LEN - 10'd1)
         begin
            st_run      <= 1'b0;
            self_res[0] <= (crc == SIG_EXPECT);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pat_prs <= PRS_SEED;
      end
      else if (act_pat[PAT_RST_A_BIT] || act_pat[PAT_RST_B_BIT])
      begin
         pat_prs <= PRS_SEED;
      end
      else if (samp_rise)
      begin
         pat_prs <= {pat_prs[10:0], pat_prs[11] ^ pat_prs[5] ^ pat_prs[3] ^ pat_prs[0]};
      end
   end

   // ---------------- datapath ----------------
   asc_sample_t fifo_out, fmt_in;
   logic        fifo_valid;
   logic        twos;
   logic [3:0]  pat_sel;
   assign pat_sel = act_pat[3:0];
   // strap when the port has never been used, register otherwise
   assign twos = spi_used ? (act_mode[1:0] == FMT_TWOS) : s_sck[1];

   asc_fifo #(.WIDTH(13), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wdata_i  (core_code_i),
      .wvalid_i (core_valid_i),
      .wready_o (core_ready_o),
      .rdata_o  (fifo_out),
      .rvalid_o (fifo_valid),
      .rready_i (samp_rise)
   );

   // core code is signed 13-bit around mid-scale; clamp to 12 bits
   logic signed [12:0] sc;
   logic        [11:0] ob;
   logic               ovr;
   always_comb
   begin
      sc  = signed'(fifo_valid ? fifo_out : 13'h0000);
      ovr = 1'b0;
      ob  = 12'(sc + 13'sd2048);
      if (sc > 13'sd2047)
      begin
         ob  = CODE_MAX;
         ovr = 1'b1;
      end
      else if (sc < -13'sd2048)
      begin
         ob  = 12'h000;
         ovr = 1'b1;
      end
      fmt_in.over = 1'b0;
      if (st_run)
      begin
         fmt_in.code = prs;
      end
      else if (pat_sel == 4'h1)
      begin
         fmt_in.code = CODE_MID;
      end
      else if (pat_sel == 4'h2)
      begin
         fmt_in.code = CODE_MAX;
      end
      else if (pat_sel == 4'h6)
      begin
         fmt_in.code = pat_prs;
      end
      else
      begin
         fmt_in.code = ob;
         fmt_in.over = ovr;
      end
      if (twos && !(pat_sel == 4'h6 && !st_run))
      begin
         fmt_in.code[11] = ~fmt_in.code[11];
      end
   end

   asc_pipe u_pipe (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .adv_i  (samp_rise),
      .din_i  (fmt_in),
      .dout_o (pipe_out)
   );

   logic tri_sel, float_out;
   assign tri_sel   = spi_used && (act_mode[MODE_FN_LSB+1:MODE_FN_LSB] == MODE_FN_TRISTATE);
   assign float_out = (tri_sel && s_oe[1]) || powerdown_o;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         data_o         <= '0;
         out_of_range_o <= 1'b0;
         dco_o          <= 1'b0;
         data_oe_n_o    <= 1'b1;
         dco_oe_n_o     <= 1'b1;
         powerdown_o    <= 1'b0;
      end
      else
      begin
         if (samp_rise)
         begin
            data_o         <= pipe_out.code;
            out_of_range_o <= pipe_out.over;
         end
         if (samp_rise || samp_fall)
         begin
            // data changes on rise; launch the data clock on the fall so its rise is centred
            dco_o <= act_phase[DCO_INV_BIT] ? samp_rise : samp_fall;
         end
         data_oe_n_o <= float_out;
         dco_oe_n_o  <= float_out;
         powerdown_o <= !spi_used && cs_n && s_sdi[1];
      end
   end
endmodule

// ===== asc_top_sva.sv
`timescale 1ns/10ps
module asc_top_sva (
   input wire logic        clk_i,           // clock
   input wire logic        rst_i,           // reset
   input wire logic        samp_clk_i,      // sample clock
   input wire logic [12:0] core_code_i,     // core code
   input wire logic        core_valid_i,    // core valid
   input wire logic        tristate_pin_i,  // float pin
   input wire logic        chip_select_n_i, // select
   input wire logic        sclk_i,          // shift clock
   input wire logic        sdio_i,          // data in
   input wire logic        sdio_o,          // data out
   input wire logic        sdio_oe_n_o,     // data drive
   input wire logic [11:0] data_o,          // outputs
   input wire logic        data_oe_n_o,     // output drive
   input wire logic        out_of_range_o,  // range flag
   input wire logic        dco_o,           // data clock
   input wire logic        dco_oe_n_o,      // clock drive
   input wire logic        powerdown_o,     // power-down
   input wire logic        core_ready_o     // not full
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> data_oe_n_o && sdio_oe_n_o && data_o == 12'h000)
      else $error("outputs active after reset");
   a_ready_reset: assert property (disable iff (1'b0) rst_i |=> core_ready_o)
      else $error("buffer not ready after reset");
   a_sdio_idle: assert property (chip_select_n_i [*5] |-> sdio_oe_n_o)
      else $error("data pin driven while deselected");
   a_sdio_turn: assert property ($fell(sdio_oe_n_o) |-> !chip_select_n_i && !$past(chip_select_n_i, 8))
      else $error("data pin turned outside a frame");
   a_sdio_hold: assert property ((sclk_i && !sdio_oe_n_o) [*3] |-> $stable(sdio_o))
      else $error("read bit changed while shift clock high");
   a_data_hold: assert property (!samp_clk_i [*4] |-> $stable(data_o))
      else $error("outputs changed without a sample edge");
   a_range_clamp: assert property (out_of_range_o |-> data_o inside {12'h000, 12'hFFF, 12'h800, 12'h7FF})
      else $error("range flag without clamped code");
   a_float_pair: assert property ((dco_oe_n_o == data_oe_n_o) and (powerdown_o |=> data_oe_n_o))
      else $error("data clock and data float apart");
endmodule
bind asc_top asc_top_sva chk (.clk_i(clk_i), .rst_i(rst_i), .samp_clk_i(samp_clk_i), .core_code_i(core_code_i),
   .core_valid_i(core_valid_i), .tristate_pin_i(tristate_pin_i), .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i),
   .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
   .out_of_range_o(out_of_range_o), .dco_o(dco_o), .dco_oe_n_o(dco_oe_n_o), .powerdown_o(powerdown_o),
   .core_ready_o(core_ready_o));

// ===== asc_host.sv
`timescale 1ns/10ps
module asc_host (
   input  wire logic clk_i,           // clock
   input  wire logic sdio_o,          // device data
   input  wire logic sdio_oe_n_o,     // device drive
   output logic      chip_select_n_o, // select
   output logic      sclk_o,          // shift clock
   output logic      line_o           // data line
);
   logic en = 1'b0;
   logic hb = 1'b0;
   logic last = 1'b0;
   logic lsb = 1'b0;
   initial chip_select_n_o = 1'b1;
   initial sclk_o = 1'b0;
   // a released line toggles so a late turnaround cannot read as valid
   assign line_o = !sdio_oe_n_o ? sdio_o : (en ? hb : !last);
   always @(posedge clk_i)
      last <= line_o;
   task automatic strap(input logic p, input logic f);
      en = 1'b1;
      hb = p;
      sclk_o = f;
   endtask
   task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
      logic [23:0] sh;
      logic [23:0] r;
      sh = {rd, 2'b00, a, wd};
      // lsb first reverses instruction and data byte separately
      for (int j = 0; j < 16; j++)
         r[23 - j] = sh[8 + j];
      for (int j = 0; j < 8; j++)
         r[7 - j] = sh[j];
      if (lsb)
         sh = r;
      q = 8'h00;
      chip_select_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      for (int i = 23; i >= 0; i--)
      begin
         en = !(rd && i < 8);
         hb = sh[i];
         sclk_o = 1'b0;
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b1;
         if (i < 8)
            q[lsb ? 7 - i : i] = line_o;
         repeat (4) @(negedge clk_i);
      end
      sclk_o = 1'b0;
      en = 1'b0;
      repeat (4) @(negedge clk_i);
      chip_select_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
endmodule

// ===== tb_asc_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_asc_top;
   import asc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        samp = 1'b0;
   logic        tpin = 1'b1;
   logic [12:0] code = 13'h0000;
   logic [12:0] e;
   logic [11:0] data;
   logic [7:0]  q;
   logic        cs_n, sclk, line, sdo, sdo_oe_n, data_oe_n, oor, dco_oe_n, pd, data_clock_out;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          seed = 58946;
   logic signed [12:0] codes [7] = '{13'sd0, -13'sd2048, 13'sd2047, 13'sd2100, -13'sd2100, 13'sd1, 13'sd1};
   asc_top uut (.clk_i(clk_i), .rst_i(rst_i), .samp_clk_i(samp), .core_code_i(code), .core_valid_i(1'b1),
      .tristate_pin_i(tpin), .chip_select_n_i(cs_n), .sclk_i(sclk), .sdio_i(line), .sdio_o(sdo),
      .sdio_oe_n_o(sdo_oe_n), .data_o(data), .data_oe_n_o(data_oe_n), .out_of_range_o(oor), .dco_o(data_clock_out),
      .dco_oe_n_o(dco_oe_n), .powerdown_o(pd), .core_ready_o());
   asc_host host (.clk_i(clk_i), .sdio_o(sdo), .sdio_oe_n_o(sdo_oe_n), .chip_select_n_o(cs_n), .sclk_o(sclk),
      .line_o(line));
   initial forever #5 clk_i = ~clk_i;
   function automatic logic [12:0] exp_out(input logic signed [12:0] c, input logic twos);
      logic [11:0] v;
      logic        f;
      f = (c > 13'sd2047) || (c < -13'sd2048);
      v = f ? (c[12] ? 12'h000 : CODE_MAX) : 12'(c + 13'sd2048);
      v[11] = v[11] ^ twos;
      return {v, f};
   endfunction
   function automatic logic [11:0] prs_at(input int n);
      logic [11:0] p;
      p = PRS_SEED;
      repeat (n) p = {p[10:0], p[11] ^ p[5] ^ p[3] ^ p[0]};
      return p;
   endfunction
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.frame(1'b0, a, d, q);
   endtask
   task automatic pulses(input int n);
      repeat (n)
      begin
         samp = 1'b1;
         repeat (5) @(negedge clk_i);
         samp = 1'b0;
         repeat (5) @(negedge clk_i);
      end
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      host.strap(1'b1, 1'b0);
      repeat (6) @(negedge clk_i);
      `CHK("powerdown", 1'b1, pd)
      host.strap(1'b0, 1'b0);
      repeat (6) @(negedge clk_i);
      `CHK("powerdown", 1'b0, pd)
      `CHK("data_oe_n", 1'b0, data_oe_n)
      $display("test straps done");
      codes[5] = 13'($random(seed) % 2048);
      codes[6] = 13'($random(seed) % 2048);
      for (int t = 0; t < 2; t++)
      begin
         if (t == 1)
         begin
            wr(ADDR_OUT_MODE, 8'h01);
            wr(ADDR_XFER, XFER_CMD);
         end
         foreach (codes[k])
         begin
            code = codes[k];
            // twenty edges flush the buffer and the pipe of older codes
            pulses(20);
            e = exp_out(codes[k], t[0]);
            `CHK("data", e[12:1], data)
            `CHK("range", e[0], oor)
         end
      end
      $display("test coding done");
      wr(ADDR_OUT_MODE, 8'h20);
      `CHK("data_oe_n", 1'b0, data_oe_n)
      wr(ADDR_XFER, XFER_CMD);
      `CHK("dco_oe_n", 1'b1, dco_oe_n)
      tpin = 1'b0;
      repeat (6) @(negedge clk_i);
      `CHK("data_oe_n", 1'b0, data_oe_n)
      host.frame(1'b1, ADDR_OUT_MODE, 8'h00, q);
      `CHK("readback", 8'h20, q)
      host.frame(1'b1, ADDR_XFER, 8'h00, q);
      `CHK("transfer", 8'h00, q)
      $display("test tristate done");
      wr(ADDR_TEST_PAT, 8'h02);
      wr(ADDR_XFER, XFER_CMD);
      pulses(20);
      `CHK("pattern", CODE_MAX, data)
      `CHK("dco", 1'b1, data_clock_out)
      wr(ADDR_TEST_PAT, 8'h00);
      wr(ADDR_SELF_CTRL, 8'h01);
      wr(ADDR_XFER, XFER_CMD);
      pulses(20);
      `CHK("self_word", prs_at(10), data)
      `CHK("data_oe_n", 1'b0, data_oe_n)
      pulses(510);
      host.frame(1'b1, ADDR_SELF_RES, 8'h00, q);
      `CHK("self_test", 1'b0, q[0])
      wr(ADDR_SELF_CTRL, 8'h05);
      pulses(20);
      `CHK("self_init", prs_at(10), data)
      pulses(510);
      $display("test self test done");
      wr(ADDR_OUT_PHASE, 8'h80);
      wr(ADDR_XFER, XFER_CMD);
      pulses(1);
      `CHK("dco_inv", 1'b0, data_clock_out)
      wr(ADDR_PORT_CFG, 8'h58);
      host.lsb = 1'b1;
      host.frame(1'b1, ADDR_PORT_CFG, 8'h00, q);
      `CHK("port_cfg", 8'h58, q)
      host.frame(1'b1, ADDR_OUT_MODE, 8'h00, q);
      `CHK("lsb_read", 8'h20, q)
      $display("test bit order done");
      give_verdict();
   end
   initial
   begin
      #900000;
      n_mismatch++;
      give_verdict();
   end
endmodule
